// file: core/stepper_pkg.sv
package stepper_pkg;

    // Bus and position widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int POS_W  = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CFG_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] ENDOFS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h08;
    localparam logic [ADDR_W-1:0] POS_OFS    = 8'h0C;
    localparam int                NREG       = 4;

    // Input mode codes
    typedef logic [2:0] mode_t;
    localparam mode_t MODE_SWITCH    = 3'h0;
    localparam mode_t MODE_DUAL_LO   = 3'h1;
    localparam mode_t MODE_DUAL_HI   = 3'h2;
    localparam mode_t MODE_SINGLE_LO = 3'h3;
    localparam mode_t MODE_SINGLE_HI = 3'h4;
    localparam mode_t MODE_QUAD_X1   = 3'h5;
    localparam mode_t MODE_QUAD_X2   = 3'h6;
    localparam mode_t MODE_QUAD_X4   = 3'h7;
    // Used when both the setting and the switch read zero
    localparam mode_t MODE_SW_DEFAULT = MODE_DUAL_HI;

    // Power-up parameter word, mode in the low bits
    typedef struct packed {
        logic  con_nc;      // Current-on input normally closed
        logic  auto_ret;    // Return to last stop position
        logic  exc_zero;    // First excitation at electrical zero
        logic  dir_pos_cw;  // Positive direction is clockwise
        mode_t mode;        // Pulse input mode
    } cfg_s;
    localparam int   CFG_W   = $bits(cfg_s);
    localparam cfg_s CFG_RST = '{con_nc: 1'b0, auto_ret: 1'b0, exc_zero: 1'b0,
                                 dir_pos_cw: 1'b1, mode: MODE_SWITCH};

    // Completion band offset, tenths of a degree
    localparam int                 OFS_W          = 8;
    localparam logic signed [OFS_W-1:0] OFS_MAX   = 8'sh12;
    localparam logic signed [OFS_W-1:0] OFS_RST   = 8'sh00;
    localparam int                 TENTHS_PER_REV = 3600;

    // Synchronised pin vector layout
    localparam int PIN_STEP   = 0;
    localparam int PIN_DIR    = 1;
    localparam int PIN_FWD    = 2;
    localparam int PIN_REV    = 3;
    localparam int PIN_CON    = 4;
    localparam int PIN_FREE   = 5;
    localparam int PIN_SW_LSB = 6;
    localparam int NPIN       = 9;

    // Status word layout
    localparam int ST_EXC      = 0;
    localparam int ST_END      = 1;
    localparam int ST_ZERO     = 2;
    localparam int ST_DIRCW    = 3;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_PEND     = 7;

    // Cycles after reset release before parameters are taken
    localparam logic [2:0] LOAD_DLY = 3'h4;

    // Excitation state machine
    typedef enum logic [2:0] {
        EXC_PWRUP = 3'b001,
        EXC_OFF   = 3'b010,
        EXC_ON    = 3'b100
    } exc_e;

endpackage

// file: core/step_if.sv
`timescale 1ns/1ns
`default_nettype none

// Pin levels to the step decoder, step strobes back
interface step_if;
    import stepper_pkg::*;
    mode_t mode;      // Resolved input mode
    logic  lvl_step;  // Step pulse level
    logic  lvl_dir;   // Direction level
    logic  lvl_a;     // Forward channel level
    logic  lvl_b;     // Reverse channel level
    logic  fwd;       // One-cycle forward step
    logic  rev;       // One-cycle reverse step
    modport core (output mode, lvl_step, lvl_dir, lvl_a, lvl_b, input fwd, rev);
    modport dec  (input mode, lvl_step, lvl_dir, lvl_a, lvl_b, output fwd, rev);
endinterface

`default_nettype wire

// file: core/step_decoder.sv
`timescale 1ns/1ns
`default_nettype none

module step_decoder
    import stepper_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    step_if.dec      sif
);

    typedef struct packed {
        logic prev_step;  // Last step level
        logic prev_a;     // Last forward channel level
        logic prev_b;     // Last reverse channel level
        logic fwd;        // Forward strobe
        logic rev;        // Reverse strobe
    } dec_s;

    dec_s dec_ff;
    dec_s nxt_dec;

    // Active edge of a pulse line for the chosen polarity
    function automatic logic act_edge(input logic prev, input logic now, input logic hi);
        return hi ? (~prev & now) : (prev & ~now);
    endfunction

    // Edge and phase decoding per mode
    always_comb begin
        logic hi;
        logic e;
        logic a_chg;
        logic b_chg;
        hi = 1'b0;
        e = 1'b0;
        a_chg = dec_ff.prev_a ^ sif.lvl_a;
        b_chg = dec_ff.prev_b ^ sif.lvl_b;
        nxt_dec = dec_ff;
        nxt_dec.prev_step = sif.lvl_step;
        nxt_dec.prev_a = sif.lvl_a;
        nxt_dec.prev_b = sif.lvl_b;
        nxt_dec.fwd = 1'b0;
        nxt_dec.rev = 1'b0;
        unique case (sif.mode)
            MODE_DUAL_LO, MODE_DUAL_HI: begin
                // Each channel steps on its own active edge
                hi = (sif.mode == MODE_DUAL_HI);
                nxt_dec.fwd = act_edge(dec_ff.prev_a, sif.lvl_a, hi);
                nxt_dec.rev = act_edge(dec_ff.prev_b, sif.lvl_b, hi);
            end
            MODE_SINGLE_LO, MODE_SINGLE_HI: begin
                // Direction level picks the sense of each step
                hi = (sif.mode == MODE_SINGLE_HI);
                e = act_edge(dec_ff.prev_step, sif.lvl_step, hi);
                nxt_dec.fwd = e & sif.lvl_dir;
                nxt_dec.rev = e & ~sif.lvl_dir;
            end
            MODE_QUAD_X1: begin
                // Rising edge of the forward channel only
                e = ~dec_ff.prev_a & sif.lvl_a & ~b_chg;
                nxt_dec.fwd = e & ~sif.lvl_b;
                nxt_dec.rev = e & sif.lvl_b;
            end
            MODE_QUAD_X2: begin
                // Both edges of the forward channel
                e = a_chg & ~b_chg;
                nxt_dec.fwd = e & (sif.lvl_a ^ sif.lvl_b);
                nxt_dec.rev = e & ~(sif.lvl_a ^ sif.lvl_b);
            end
            MODE_QUAD_X4: begin
                // Every single edge; a double change is a skipped state and dropped
                e = a_chg ^ b_chg;
                nxt_dec.fwd = e & (sif.lvl_a ^ dec_ff.prev_b);
                nxt_dec.rev = e & ~(sif.lvl_a ^ dec_ff.prev_b);
            end
            default: begin
                // Unresolved mode never reaches here; no steps
                nxt_dec.fwd = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    assign sif.fwd = dec_ff.fwd;
    assign sif.rev = dec_ff.rev;

endmodule

`default_nettype wire

// file: core/stepper_pulse_command_input.sv
`timescale 1ns/1ns
`default_nettype none

module stepper_pulse_command_input
    import stepper_pkg::*;
#(
    parameter bit AC_VARIANT    = 1'b1,  // Return on main power-on
    parameter int ELEC_STEPS    = 20,    // Steps per electrical cycle
    parameter int STEPS_PER_REV = 1000,  // Command resolution
    parameter int END_BAND      = 1      // Half width of completion band
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              cold_rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              step_pulse_in,
    input  wire logic              dir_in,
    input  wire logic              forward_pulse_in,
    input  wire logic              reverse_pulse_in,
    input  wire logic              con_in,
    input  wire logic              free_in,
    input  wire logic [2:0]        mode_sw_in,
    input  wire logic [POS_W-1:0]  actual_pos_in,
    output logic                   step_out,
    output logic                   dir_cw_out,
    output logic                   excite_out,
    output logic                   zero_excite_out,
    output logic                   auto_return_out,
    output logic                   end_out,
    output logic                   electrical_zero_out
);

    localparam int ELEC_W = $clog2(ELEC_STEPS);

    // Refuse settings the counters cannot serve
    if (ELEC_STEPS < 2) begin : g_bad_elec
        $error("ELEC_STEPS must be at least 2");
    end
    if (STEPS_PER_REV < 1 || END_BAND < 0) begin : g_bad_res
        $error("STEPS_PER_REV and END_BAND out of range");
    end

    // Parameter store, survives the driver reset
    typedef struct packed {
        cfg_s                     cfg;  // Written power-up parameters
        logic signed [OFS_W-1:0]  ofs;  // Completion band offset, live
    } store_s;

    // Driver state
    typedef struct packed {
        logic [NPIN-1:0]   s1;        // Pin sampler, first stage
        logic [NPIN-1:0]   s2;        // Second stage
        logic [NPIN-1:0]   s3;        // Third stage
        logic [NPIN-1:0]   pin;       // Filtered pin levels
        logic              free_prev; // Last release level
        exc_e              st;        // Excitation state
        logic [2:0]        dly;       // Settling count after reset
        cfg_s              act;       // Parameters in force
        mode_t             mode;      // Resolved input mode
        logic              first;     // First excitation done
        logic [POS_W-1:0]  cmd_pos;   // Command position
        logic [ELEC_W-1:0] elec;      // Electrical phase step
        logic              step_o;    // Step strobe
        logic              dir_o;     // Shaft sense of last step
        logic              exc_o;     // Motor energized
        logic              zero_o;    // Excite at electrical zero
        logic              ret_o;     // Auto return request
        logic              end_o;     // Positioning complete
        logic              ezero_o;   // Electrical zero timing
        logic [DATA_W-1:0] prdata;    // Read data
        logic              pready;    // Bus answer
        logic              pslverr;   // Unmapped address
    } core_s;

    store_s store_ff;
    store_s nxt_store;
    core_s  core_ff;
    core_s  nxt_core;

    // Decoder link
    step_if sif ();

    // One-hot register select, shared by read and write paths
    function automatic logic [NREG-1:0] reg_sel(input logic [ADDR_W-1:0] a);
        reg_sel = {a == POS_OFS, a == STAT_OFS, a == ENDOFS_OFS, a == CFG_OFS};
    endfunction

    // Mode switch covers setting zero; a zero switch falls back
    function automatic mode_t resolve_mode(input mode_t cfg_mode, input mode_t sw);
        if (cfg_mode != MODE_SWITCH) begin
            resolve_mode = cfg_mode;
        end else if (sw != MODE_SWITCH) begin
            resolve_mode = sw;
        end else begin
            resolve_mode = MODE_SW_DEFAULT;
        end
    endfunction

    // Completion offset scaled from tenths of a degree to counts
    logic signed [POS_W-1:0] ofs_cnt;
    logic signed [POS_W-1:0] dev;
    logic signed [POS_W-1:0] dev_abs;
    logic                    in_band;
    // Pins agreeing over the last two samples
    logic [NPIN-1:0]         agree;
    logic [NPIN-1:0]         pins_raw;
    // Write strobe at the access edge
    logic                    wr_en;
    logic [NREG-1:0]         wr_sel;

    assign pins_raw = {mode_sw_in, free_in, con_in, reverse_pulse_in,
                       forward_pulse_in, dir_in, step_pulse_in};
    assign agree    = ~(core_ff.s2 ^ core_ff.s3);
    assign wr_en    = psel & penable & pwrite & core_ff.pready & ~core_ff.pslverr;
    assign wr_sel   = reg_sel(paddr);

    // Band test on the stopped deviation, shifted by the offset
    always_comb begin
        int ofs_i;
        ofs_i = int'(store_ff.ofs) * STEPS_PER_REV / TENTHS_PER_REV;
        ofs_cnt = POS_W'(ofs_i);
        dev = $signed(core_ff.cmd_pos - actual_pos_in) - ofs_cnt;
        dev_abs = dev[POS_W-1] ? -dev : dev;
        in_band = (dev_abs <= POS_W'(END_BAND));
    end

    // Parameter store: config writes land here, not in the live set; the offset is used as stored
    always_comb begin
        logic signed [OFS_W-1:0] w;
        w = pwdata[OFS_W-1:0];
        nxt_store = store_ff;
        if (wr_en && wr_sel[0]) begin
            nxt_store.cfg = cfg_s'(pwdata[CFG_W-1:0]);
        end
        if (wr_en && wr_sel[1]) begin
            // Clamp to the legal band offset range
            if (w > OFS_MAX) begin
                nxt_store.ofs = OFS_MAX;
            end else if (w < -OFS_MAX) begin
                nxt_store.ofs = -OFS_MAX;
            end else begin
                nxt_store.ofs = w;
            end
        end
    end

    // Store register on the cold reset only
    always_ff @(posedge pclk or negedge cold_rstn) begin
        if (!cold_rstn) begin
            store_ff <= '{cfg: CFG_RST, ofs: OFS_RST};
        end else begin
            store_ff <= nxt_store;
        end
    end

    // Main next-state logic
    always_comb begin
        logic con_act;
        logic free_fall;
        logic fwd_s;
        logic rev_s;
        logic [DATA_W-1:0] stat;
        logic [NREG-1:0] sel;
        // Polarity applied to current-on; release edge for return
        con_act = core_ff.pin[PIN_CON] ^ core_ff.act.con_nc;
        free_fall = core_ff.free_prev & ~core_ff.pin[PIN_FREE];
        // Opposite strobes in one cycle cancel
        fwd_s = sif.fwd & ~sif.rev;
        rev_s = sif.rev & ~sif.fwd;
        stat = '0;
        sel = reg_sel(paddr);
        nxt_core = core_ff;

        // Three-stage sampler; a level counts once stages two and three agree
        nxt_core.s1 = pins_raw;
        nxt_core.s2 = core_ff.s1;
        nxt_core.s3 = core_ff.s2;
        nxt_core.pin = (agree & core_ff.s3) | (~agree & core_ff.pin);
        nxt_core.free_prev = core_ff.pin[PIN_FREE];

        // Strobes last one cycle
        nxt_core.step_o = 1'b0;
        nxt_core.zero_o = 1'b0;
        nxt_core.ret_o = 1'b0;

        // Excitation sequence
        unique case (core_ff.st)
            EXC_PWRUP: begin
                // Wait for the sampler to settle before taking parameters
                if (core_ff.dly == LOAD_DLY) begin
                    nxt_core.act = store_ff.cfg;
                    nxt_core.mode = resolve_mode(store_ff.cfg.mode,
                        core_ff.pin[PIN_SW_LSB +: 3]);
                    nxt_core.st = EXC_OFF;
                    // Main power-on return on the mains-fed variant
                    nxt_core.ret_o = AC_VARIANT & store_ff.cfg.auto_ret;
                end else begin
                    nxt_core.dly = core_ff.dly + 3'h1;
                end
            end
            EXC_OFF: begin
                // A closed-contact input is already active: no edge needed
                if (con_act) begin
                    nxt_core.st = EXC_ON;
                    if (!core_ff.first) begin
                        // First excitation: zero angle if asked or closed contact
                        nxt_core.zero_o = core_ff.act.exc_zero
                                        | core_ff.act.con_nc;
                    end else begin
                        nxt_core.ret_o = core_ff.act.auto_ret;
                    end
                    nxt_core.first = 1'b1;
                end
            end
            EXC_ON: begin
                if (!con_act) begin
                    nxt_core.st = EXC_OFF;
                end else if (free_fall) begin
                    nxt_core.ret_o = core_ff.act.auto_ret;
                end
            end
            default: begin
                // Corrupt state code: restart the power-up sequence
                nxt_core.st = EXC_PWRUP;
            end
        endcase

        // Shaft release holds the motor unenergized
        nxt_core.exc_o = (nxt_core.st == EXC_ON) & ~core_ff.pin[PIN_FREE];

        // Steps are taken only while energized
        if (core_ff.exc_o && (fwd_s || rev_s)) begin
            nxt_core.step_o = 1'b1;
            if (fwd_s) begin
                nxt_core.cmd_pos = core_ff.cmd_pos + POS_W'(1);
                nxt_core.dir_o = core_ff.act.dir_pos_cw;
                if (core_ff.elec == ELEC_W'(ELEC_STEPS - 1)) begin
                    nxt_core.elec = '0;
                end else begin
                    nxt_core.elec = core_ff.elec + ELEC_W'(1);
                end
            end else begin
                nxt_core.cmd_pos = core_ff.cmd_pos - POS_W'(1);
                nxt_core.dir_o = ~core_ff.act.dir_pos_cw;
                if (core_ff.elec == '0) begin
                    nxt_core.elec = ELEC_W'(ELEC_STEPS - 1);
                end else begin
                    nxt_core.elec = core_ff.elec - ELEC_W'(1);
                end
            end
        end

        // Exciting at zero angle resets the electrical phase
        if (nxt_core.zero_o) begin
            nxt_core.elec = '0;
        end
        nxt_core.ezero_o = (nxt_core.elec == '0);

        // Completion only when energized and not stepping
        nxt_core.end_o = core_ff.exc_o & ~core_ff.step_o & ~fwd_s & ~rev_s
                       & in_band;

        // Status word
        stat[ST_EXC] = core_ff.exc_o;
        stat[ST_END] = core_ff.end_o;
        stat[ST_ZERO] = core_ff.ezero_o;
        stat[ST_DIRCW] = core_ff.dir_o;
        stat[ST_MODE_LSB +: 3] = core_ff.mode;
        // Stored parameters differ from those in force until restart
        stat[ST_PEND] = (store_ff.cfg != core_ff.act);

        // Bus slave: answer in the first access cycle
        nxt_core.pready = 1'b0;
        nxt_core.pslverr = 1'b0;
        if (psel && !penable) begin
            nxt_core.pready = 1'b1;
            nxt_core.pslverr = ~(|sel);
            unique case (1'b1)
                sel[0]: nxt_core.prdata = DATA_W'(store_ff.cfg);
                sel[1]: nxt_core.prdata = DATA_W'(unsigned'(store_ff.ofs));
                sel[2]: nxt_core.prdata = stat;
                sel[3]: nxt_core.prdata = DATA_W'(core_ff.cmd_pos);
                default: nxt_core.prdata = '0;
            endcase
        end
    end

    // Driver state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ff <= '{s1: '0, s2: '0, s3: '0, pin: '0, free_prev: 1'b0,
                         st: EXC_PWRUP, dly: 3'h0, act: CFG_RST,
                         mode: MODE_SW_DEFAULT, first: 1'b0, cmd_pos: '0,
                         elec: '0, step_o: 1'b0, dir_o: 1'b0, exc_o: 1'b0,
                         zero_o: 1'b0, ret_o: 1'b0, end_o: 1'b0,
                         ezero_o: 1'b0, prdata: '0, pready: 1'b0,
                         pslverr: 1'b0};
        end else begin
            core_ff <= nxt_core;
        end
    end

    // Decoder sees filtered pins; the two quadrature channels share the pulse lines
    assign sif.mode     = core_ff.mode;
    assign sif.lvl_step = core_ff.pin[PIN_STEP];
    assign sif.lvl_dir  = core_ff.pin[PIN_DIR];
    assign sif.lvl_a    = core_ff.pin[PIN_FWD];
    assign sif.lvl_b    = core_ff.pin[PIN_REV];

    step_decoder u_dec (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    // Outputs straight from flops
    assign prdata              = core_ff.prdata;
    assign pready              = core_ff.pready;
    assign pslverr             = core_ff.pslverr;
    assign step_out            = core_ff.step_o;
    assign dir_cw_out          = core_ff.dir_o;
    assign excite_out          = core_ff.exc_o;
    assign zero_excite_out     = core_ff.zero_o;
    assign auto_return_out     = core_ff.ret_o;
    assign end_out             = core_ff.end_o;
    assign electrical_zero_out = core_ff.ezero_o;

endmodule

`default_nettype wire

// file: verification/stepper_props.sv
`timescale 1ns/1ns
`default_nettype none

// Port-level timing checks of the pulse command block
module stepper_props
    import stepper_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic step_out,
    input wire logic excite_out,
    input wire logic zero_excite_out,
    input wire logic auto_return_out,
    input wire logic end_out,
    input wire logic electrical_zero_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setup phase of an APB transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    property p_rdy; s_setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
    // Pins hold four cycles, so steps never come back to back
    property p_stp; step_out |=> !step_out; endproperty
    a_stp: assert property (p_stp) else $error("step too long");
    property p_stx; step_out |-> excite_out || $past(excite_out); endproperty
    a_stx: assert property (p_stx) else $error("step unexcited");
    property p_zex; zero_excite_out |-> ##[0:2] electrical_zero_out; endproperty
    a_zex: assert property (p_zex) else $error("no zero phase");
    property p_zp; zero_excite_out |=> !zero_excite_out; endproperty
    a_zp: assert property (p_zp) else $error("zero pulse long");
    property p_ret; auto_return_out |=> !auto_return_out; endproperty
    a_ret: assert property (p_ret) else $error("return pulse long");
    // Completion waits one cycle after any step
    property p_end; step_out |=> !end_out; endproperty
    a_end: assert property (p_end) else $error("end while moving");
endmodule

bind stepper_pulse_command_input stepper_props u_props (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .step_out, .excite_out, .zero_excite_out, .auto_return_out,
    .end_out, .electrical_zero_out);

`default_nettype wire

// file: verification/pulse_gen.sv
`timescale 1ns/1ns
`default_nettype none

// Controller model: pins move after a rising edge, each level stands 4 cycles
module pulse_gen
    import stepper_pkg::*;
(
    input  wire logic pclk,
    output logic      step_pulse_in,
    output logic      dir_in,
    output logic      forward_pulse_in,
    output logic      reverse_pulse_in
);
    mode_t cur_mode;  // Format the controller emits

    task automatic hold();
        repeat (4) @(posedge pclk); // Sharp edges, long levels
    endtask

    // Inactive levels of the chosen format
    task automatic idle(input mode_t md);
        cur_mode = md;
        step_pulse_in <= (md == MODE_SINGLE_LO);
        forward_pulse_in <= (md == MODE_DUAL_LO);
        reverse_pulse_in <= (md == MODE_DUAL_LO);
        dir_in <= 1'b0;
        hold();
    endtask

    // One command unit; in quadrature a full cycle of four edges
    task automatic pulse(input logic fwd);
        case (cur_mode)
            MODE_DUAL_LO, MODE_DUAL_HI: begin
                repeat (2) begin
                    if (fwd)
                        forward_pulse_in <= ~forward_pulse_in;
                    else
                        reverse_pulse_in <= ~reverse_pulse_in;
                    hold();
                end
            end
            MODE_SINGLE_LO, MODE_SINGLE_HI: begin
                dir_in <= fwd;
                hold();
                repeat (2) begin
                    step_pulse_in <= ~step_pulse_in;
                    hold();
                end
            end
            default: repeat (4) begin // Reverse channel lags when forward
                if ((forward_pulse_in == reverse_pulse_in) == fwd)
                    forward_pulse_in <= ~forward_pulse_in;
                else
                    reverse_pulse_in <= ~reverse_pulse_in;
                hold();
            end
        endcase
    endtask

    initial idle(MODE_DUAL_HI);
endmodule

`default_nettype wire

// file: verification/test_stepper_pulse_command_input.sv
`timescale 1ns/1ns
`default_nettype none

module test_stepper_pulse_command_input
    import stepper_pkg::*;
;
    logic        pclk = 0, presetn = 0, cold_rstn = 0, con_in = 0;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic        step_out, dir_cw_out, step_pulse_in, dir_in;
    logic        forward_pulse_in, reverse_pulse_in;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [32:0] rq[$];  // Expected {pslverr, prdata}
    logic        dq[$];  // Expected shaft sense per step
    int          n_fail = 0, n_compared = 0, nf, nr, mul;
    cfg_s        cfg;
    mode_t       md;

    always #5 pclk = ~pclk;

    stepper_pulse_command_input uut (.pclk, .presetn, .cold_rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .step_pulse_in, .dir_in,
        .forward_pulse_in, .reverse_pulse_in, .con_in, .free_in(1'b0),
        .mode_sw_in(MODE_SINGLE_HI), .actual_pos_in(32'h0), .step_out, .dir_cw_out,
        .excite_out(), .zero_excite_out(), .auto_return_out(), .end_out(),
        .electrical_zero_out());
    pulse_gen pg (.pclk, .step_pulse_in, .dir_in, .forward_pulse_in, .reverse_pulse_in);

    task automatic chk(input string s, input logic [32:0] e, input logic [32:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic test_done();
        if (rq.size() || dq.size())
            n_fail++;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
        if (i >= 20) begin
            n_fail++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Oldest note leaves its queue as each answer or step shows
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("prdata", rq.size() ? rq.pop_front() : 'x, {pslverr, prdata});
        if (step_out === 1'b1)
            chk("dir_cw_out", dq.size() ? dq.pop_front() : 'x, dir_cw_out);
    end

    initial begin
        void'($urandom(32'hDB58));
        repeat (8) @(posedge pclk);
        cold_rstn <= 1'b1;
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(CFG_OFS, 33'h8);
        apb(1'b1, ENDOFS_OFS, 32'h7F);
        rd(ENDOFS_OFS, 33'h12);
        apb(1'b1, ENDOFS_OFS, 32'hE0);
        rd(ENDOFS_OFS, 33'hEE);
        rd(8'h10, 33'h1_0000_0000); // Unmapped place answers with an error
        $display("register test done");
        // Every mode code, each after its own power cycle
        for (int m = 0; m < 8; m++) begin
            md = (m == 0) ? MODE_SINGLE_HI : mode_t'(m);
            cfg = '{con_nc: 1'b0, auto_ret: m[1], exc_zero: m[2], dir_pos_cw: m[0],
                    mode: mode_t'(m)};
            apb(1'b1, CFG_OFS, 32'(cfg));
            rd(CFG_OFS, 33'(cfg));
            con_in <= 1'b0;
            repeat (8) @(posedge pclk);
            pg.idle(md);
            presetn <= 1'b0;
            @(posedge pclk) presetn <= 1'b1;
            repeat (8) @(posedge pclk);
            pg.pulse(1'b1); // Not energized yet, so no step is expected
            con_in <= 1'b1;
            repeat (8) @(posedge pclk);
            nf = $urandom_range(3, 1);
            nr = $urandom_range(2, 1);
            mul = (md == MODE_QUAD_X4) ? 4 : (md == MODE_QUAD_X2) ? 2 : 1;
            for (int i = 0; i < nf + nr; i++) begin
                repeat (mul) dq.push_back((i < nf) == m[0]);
                pg.pulse(i < nf);
            end
            repeat (10) @(posedge pclk);
            rd(POS_OFS, {1'b0, 32'((nf - nr) * mul)});
            $display("mode %0d test done", m);
        end
        test_done();
    end
endmodule

`default_nettype wire
